// file: logic/fpxu_map.vh
// Purpose: constants for the floating-point exception flag/mask unit
// Assumes: included by fpxu_top.v only
// Notes:   register offsets are byte addresses on the plain register port
`ifndef FPXU_MAP_VH
`define FPXU_MAP_VH

// register offsets
`define FPXU_OFS_STK_CTRL   8'h00
`define FPXU_OFS_STK_STAT   8'h04
`define FPXU_OFS_SIMD_CSR   8'h08

// exception class bit positions, shared by flags and masks
`define FPXU_B_INVALID      0
`define FPXU_B_DENORM       1
`define FPXU_B_ZDIV         2
`define FPXU_B_OVF          3
`define FPXU_B_UNF          4
`define FPXU_B_PREC         5

// field positions
`define FPXU_STK_RC_LO      10
`define FPXU_SIMD_MASK_LO   7
`define FPXU_SIMD_RC_LO     13

// reset values
`define FPXU_RST_MASKS      6'h3f
`define FPXU_RST_FLAGS      6'h00
`define FPXU_RST_RC         2'h0

// rounding control encodings
`define FPXU_RC_NEAR        2'h0
`define FPXU_RC_DOWN        2'h1
`define FPXU_RC_UP          2'h2
`define FPXU_RC_ZERO        2'h3

// destination formats
`define FPXU_FMT_SGL        2'h0
`define FPXU_FMT_DBL        2'h1
`define FPXU_FMT_EXT        2'h2

// overflow thresholds on the unbiased rounded exponent
`define FPXU_OVF_SGL        18'sh00080
`define FPXU_OVF_DBL        18'sh00400
`define FPXU_OVF_EXT        18'sh04000

// default result kinds
`define FPXU_K_INDEF        2'h0
`define FPXU_K_INF          2'h1
`define FPXU_K_MAXFIN       2'h2

`endif

// file: logic/fpxu_top.v
// Purpose: exception flag/mask logic for a scalar stack unit and a packed simd unit
// Assumes: the datapath flags operand and result conditions; inputs synchronous to CLK_I
// Notes:   register map on the plain port, byte offsets
//          0x00 stack control: masks [5:0], rounding field [11:10]
//          0x04 stack status: sticky flags [5:0]
//          0x08 simd control/status: flags [5:0], masks [12:7], rounding field [14:13]
//          flag order: invalid, denormal, zero-divide, overflow, underflow, precision
//          a flag write replaces the word, yet an event in that same cycle still sets
//          underflow and precision are flagged and trapped; no denormal result is built
//          the only priority kept is invalid over zero-divide
// Notes on behaviour
// [RULE1] invalid, zero-divide, denormal checked before computing
// [RULE2] overflow, underflow, precision checked after computing
// [RULE3] six flags, six masks; flag first, then mask
// [RULE4] masked class gives default result, no trap
// [RULE5] unmasked class invokes the software handler
// [RULE6] flags sticky until software clears them
// [RULE7] stack flags status 0-5, masks control 0-5
// [RULE8] simd flags 0-5, masks 7-12 one register
// [RULE9] stack and simd bit sets act independently
// [RULE10] masked response continues same instruction
// [RULE11] masked invalid writes indefinite quiet nan
// [RULE12] unmasked invalid traps, operands untouched
// [RULE13] masked denormal sets flag, keeps executing
// [RULE14] unmasked denormal traps, operands untouched
// [RULE15] masked zero-divide returns xor-signed infinity
// [RULE16] unmasked zero-divide traps, operands untouched
// [RULE17] overflow at 2^128, 2^1024, 2^16384
// [RULE18] masked overflow result chosen by rounding mode
// [RULE19] unmasked overflow: simd untouched, stack stores biased
// [RULE20] rounding codes: 00 near,01 down,10 up,11 zero
// [RULE21] rounding field stack bits 10-11, simd 13-14
`timescale 1ns/1ns
`include "fpxu_map.vh"

module fpxu_top (
	input  wire        CLK_I,
	input  wire        RSTN_I,
	input  wire [7:0]  ADDR_I,
	input  wire [31:0] WDATA_I,
	input  wire        WR_I,
	input  wire        RD_I,
	output reg  [31:0] RDATA_O,
	input  wire        PRE_VALID_I,
	input  wire        PRE_UNIT_I,
	input  wire [1:0]  PRE_FMT_I,
	input  wire        PRE_INVALID_I,
	input  wire        PRE_DENORM_I,
	input  wire        PRE_ZDIV_I,
	input  wire        PRE_SIGN_A_I,
	input  wire        PRE_SIGN_B_I,
	input  wire        POST_VALID_I,
	input  wire [17:0] POST_EXP_I,
	input  wire        POST_SIGN_I,
	input  wire        POST_TINY_I,
	input  wire        POST_INEXACT_I,
	input  wire [79:0] POST_DATA_I,
	input  wire [79:0] POST_BIASED_I,
	output wire        BUSY_O,
	output reg         GO_ON_O,
	output reg         TRAP_O,
	output reg         TRAP_UNIT_O,
	output reg         DEST_WE_O,
	output reg  [79:0] DEST_DATA_O,
	output reg         DONE_O
);

	// one-hot states
	// idle takes operand checks, comp waits for the rounded result
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_COMP = 2'h2;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	// architectural state: control fields and sticky flags of each unit
	reg  [5:0]  stk_mask_q;
	reg  [1:0]  stk_rc_q;
	reg  [5:0]  stk_flag_q;
	reg  [5:0]  simd_mask_q;
	reg  [1:0]  simd_rc_q;
	reg  [5:0]  simd_flag_q;
	// instruction context, captured when the operand check is taken
	reg         unit_q;
	reg  [1:0]  fmt_q;

	// state decode, one bit per state
	wire        idle = state_q[0];
	wire        comp = state_q[1];

	// builds a default result in the low bits of an 80-bit destination
	// indefinite is a negative quiet nan with the top fraction bit set
	function [79:0] fpxu_encode;
		input [1:0] kind;
		input       sgn;
		input [1:0] fmt;
		begin
			fpxu_encode = 80'h0;
			case (fmt)
				`FPXU_FMT_SGL: begin
					case (kind)
						`FPXU_K_INDEF: fpxu_encode = {48'h0, 1'b1, 8'hff, 23'h400000};
						`FPXU_K_INF:   fpxu_encode = {48'h0, sgn, 8'hff, 23'h000000};
						default:       fpxu_encode = {48'h0, sgn, 8'hfe, 23'h7fffff};
					endcase
				end
				`FPXU_FMT_DBL: begin
					case (kind)
						`FPXU_K_INDEF: fpxu_encode = {16'h0, 1'b1, 11'h7ff, 52'h8000000000000};
						`FPXU_K_INF:   fpxu_encode = {16'h0, sgn, 11'h7ff, 52'h0000000000000};
						default:       fpxu_encode = {16'h0, sgn, 11'h7fe, 52'hfffffffffffff};
					endcase
				end
				default: begin
					case (kind)
						`FPXU_K_INDEF: fpxu_encode = {1'b1, 15'h7fff, 64'hc000000000000000};
						`FPXU_K_INF:   fpxu_encode = {sgn, 15'h7fff, 64'h8000000000000000};
						default:       fpxu_encode = {sgn, 15'h7ffe, 64'hffffffffffffffff};
					endcase
				end
			endcase
		end
	endfunction

	// masked overflow answer: infinity or largest finite, by rounding mode
	// directed modes reach infinity only on the side they round toward
	function [1:0] fpxu_ovf_kind;
		input [1:0] rc;
		input       sgn;
		begin
			case (rc)
				`FPXU_RC_NEAR: fpxu_ovf_kind = `FPXU_K_INF;
				`FPXU_RC_DOWN: fpxu_ovf_kind = sgn ? `FPXU_K_INF : `FPXU_K_MAXFIN;
				`FPXU_RC_UP:   fpxu_ovf_kind = sgn ? `FPXU_K_MAXFIN : `FPXU_K_INF;
				default:       fpxu_ovf_kind = `FPXU_K_MAXFIN;
			endcase
		end
	endfunction

	// sticky flags: software write replaces, a new event in the same cycle wins
	// the or after the mux is what lets an event beat a clear
	function [5:0] fpxu_flag_next;
		input [5:0] cur;
		input       wr;
		input [5:0] wval;
		input [5:0] ev;
		begin
			fpxu_flag_next = (wr ? wval : cur) | ev;
		end
	endfunction

	// overflow threshold per destination format
	// the exponent is that of the rounded magnitude, so equality already overflows
	function fpxu_is_ovf;
		input [17:0] ex;
		input [1:0]  fmt;
		begin
			case (fmt)
				`FPXU_FMT_SGL: fpxu_is_ovf = $signed(ex) >= `FPXU_OVF_SGL;
				`FPXU_FMT_DBL: fpxu_is_ovf = $signed(ex) >= `FPXU_OVF_DBL;
				default:       fpxu_is_ovf = $signed(ex) >= `FPXU_OVF_EXT;
			endcase
		end
	endfunction

	// classes found before the arithmetic, the rest only after it
	localparam [5:0] PRE_CLASSES = 6'h07; // RULE1 RULE2

	// unit select for six-bit words, so neither unit sees the other's bits
	function [5:0] fpxu_pick6;
		input       simd;
		input [5:0] stk_val;
		input [5:0] simd_val;
		begin
			fpxu_pick6 = simd ? simd_val : stk_val;
		end
	endfunction

	// one offset match, shared by every write decode
	function fpxu_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			fpxu_hit = (addr == ofs);
		end
	endfunction

	// operand checks are taken only while idle, before any arithmetic
	// a request while busy is dropped and sets no flag
	wire        pre_take = PRE_VALID_I & idle; // RULE1
	wire        post_take = POST_VALID_I & comp; // RULE2

	// each unit only sees its own masks and rounding field
	wire [5:0]  pre_mask = fpxu_pick6(PRE_UNIT_I, stk_mask_q, simd_mask_q); // RULE9
	wire [5:0]  cur_mask = fpxu_pick6(unit_q, stk_mask_q, simd_mask_q); // RULE9
	wire [1:0]  cur_rc = unit_q ? simd_rc_q : stk_rc_q; // RULE9

	// pre-computation events; invalid outranks zero-divide
	// so that a masked pair owes only one default result
	wire        pre_inv = PRE_INVALID_I;
	wire        pre_zdv = PRE_ZDIV_I & ~PRE_INVALID_I;
	wire        pre_den = PRE_DENORM_I;
	wire [5:0]  pre_ev;
	assign pre_ev[`FPXU_B_INVALID] = pre_take & pre_inv;
	assign pre_ev[`FPXU_B_DENORM]  = pre_take & pre_den;
	assign pre_ev[`FPXU_B_ZDIV]    = pre_take & pre_zdv;
	assign pre_ev[`FPXU_B_OVF]     = 1'b0;
	assign pre_ev[`FPXU_B_UNF]     = 1'b0;
	assign pre_ev[`FPXU_B_PREC]    = 1'b0;
	wire        pre_trap = |(pre_ev & ~pre_mask); // RULE5
	wire        pre_fin = pre_ev[`FPXU_B_INVALID] | pre_ev[`FPXU_B_ZDIV];

	// post-computation events from the rounded result
	// tiny alone sets underflow; inexactness is not looked at for it
	wire        post_ovf = fpxu_is_ovf(POST_EXP_I, fmt_q); // RULE17
	wire [5:0]  post_ev;
	assign post_ev[`FPXU_B_INVALID] = 1'b0;
	assign post_ev[`FPXU_B_DENORM]  = 1'b0;
	assign post_ev[`FPXU_B_ZDIV]    = 1'b0;
	assign post_ev[`FPXU_B_OVF]     = post_take & post_ovf; // RULE2
	assign post_ev[`FPXU_B_UNF]     = post_take & POST_TINY_I; // RULE2
	assign post_ev[`FPXU_B_PREC]    = post_take & POST_INEXACT_I; // RULE2
	wire        post_trap = |(post_ev & ~cur_mask); // RULE5
	wire        ovf_unm = post_ev[`FPXU_B_OVF] & ~cur_mask[`FPXU_B_OVF];
	wire        unf_unm = post_ev[`FPXU_B_UNF] & ~cur_mask[`FPXU_B_UNF];

	// route events to the unit that raised them
	// one instruction is served at a time, so the units never share a cycle
	wire        ev_unit = idle ? PRE_UNIT_I : unit_q;
	wire [5:0]  ev_all;
	genvar      gi;

	// each class takes its event from the phase in which it is detected
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_cls
			assign ev_all[gi] = PRE_CLASSES[gi] ? pre_ev[gi] : post_ev[gi]; // RULE1 RULE2
		end
	endgenerate
	wire [5:0]  stk_ev = ev_unit ? 6'h00 : ev_all; // RULE9
	wire [5:0]  simd_ev = ev_unit ? ev_all : 6'h00; // RULE9

	// register write decode; unmapped offsets match nothing, so such writes drop
	wire        wr_sctl = WR_I & fpxu_hit(ADDR_I, `FPXU_OFS_STK_CTRL);
	wire        wr_ssts = WR_I & fpxu_hit(ADDR_I, `FPXU_OFS_STK_STAT);
	wire        wr_csr = WR_I & fpxu_hit(ADDR_I, `FPXU_OFS_SIMD_CSR);

	// read words assembled once, so the read process only selects
	wire [31:0] stk_ctrl_word = {20'h0, stk_rc_q, 4'h0, stk_mask_q}; // RULE7 RULE21
	wire [31:0] stk_stat_word = {26'h0, stk_flag_q}; // RULE7
	wire [31:0] simd_csr_word = {17'h0, simd_rc_q, simd_mask_q, 1'b0, simd_flag_q}; // RULE8 RULE21

	// control fields and sticky flags
	// masks and rounding move only on a write; flags also take events
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			stk_mask_q  <= `FPXU_RST_MASKS;
			stk_rc_q    <= `FPXU_RST_RC;
			stk_flag_q  <= `FPXU_RST_FLAGS;
			simd_mask_q <= `FPXU_RST_MASKS;
			simd_rc_q   <= `FPXU_RST_RC;
			simd_flag_q <= `FPXU_RST_FLAGS;
		end else begin
			if (wr_sctl) begin
				stk_mask_q <= WDATA_I[5:0]; // RULE7
				stk_rc_q   <= WDATA_I[`FPXU_STK_RC_LO +: 2]; // RULE21
			end
			if (wr_csr) begin
				simd_mask_q <= WDATA_I[`FPXU_SIMD_MASK_LO +: 6]; // RULE8
				simd_rc_q   <= WDATA_I[`FPXU_SIMD_RC_LO +: 2]; // RULE21
			end
			// flags are set on the same edge that registers the response
			stk_flag_q  <= fpxu_flag_next(stk_flag_q, wr_ssts, WDATA_I[5:0], stk_ev); // RULE3 RULE6 RULE7
			simd_flag_q <= fpxu_flag_next(simd_flag_q, wr_csr, WDATA_I[5:0], simd_ev); // RULE3 RULE6 RULE8
		end
	end

	// read data stands in the cycle after the strobe only
	// zero outside that cycle keeps a shared read bus quiet
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RDATA_O <= 32'h0;
		end else if (RD_I) begin
			case (ADDR_I)
				`FPXU_OFS_STK_CTRL: RDATA_O <= stk_ctrl_word; // RULE7 RULE21
				`FPXU_OFS_STK_STAT: RDATA_O <= stk_stat_word; // RULE7
				`FPXU_OFS_SIMD_CSR: RDATA_O <= simd_csr_word; // RULE8 RULE21
				default:            RDATA_O <= 32'h0;
			endcase
		end else begin
			RDATA_O <= 32'h0;
		end
	end

	// sequencer: wait for the result only when the instruction goes on
	// a trap or a masked invalid or zero-divide ends the instruction while idle
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (pre_take & ~pre_trap & ~pre_fin) begin
					state_d = ST_COMP; // RULE10 RULE13
				end
			end
			ST_COMP: begin
				if (post_take) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// busy follows the state directly, so a request in the done cycle is taken
	assign BUSY_O = comp;

	// responses; operand and simd traps never write; a stack result trap writes biased, overflow-default or rounded data
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q     <= ST_IDLE;
			unit_q      <= 1'b0;
			fmt_q       <= `FPXU_FMT_SGL;
			GO_ON_O     <= 1'b0;
			TRAP_O      <= 1'b0;
			TRAP_UNIT_O <= 1'b0;
			DEST_WE_O   <= 1'b0;
			DEST_DATA_O <= 80'h0;
			DONE_O      <= 1'b0;
		end else begin
			state_q   <= state_d;
			GO_ON_O   <= 1'b0;
			TRAP_O    <= 1'b0;
			DEST_WE_O <= 1'b0;
			DONE_O    <= 1'b0;
			// operand path: answered one cycle after the check is taken
			if (pre_take) begin
				unit_q <= PRE_UNIT_I;
				fmt_q  <= PRE_FMT_I;
				if (pre_trap) begin
					// operands and destination left as they were
					TRAP_O      <= 1'b1; // RULE5 RULE12 RULE14 RULE16
					TRAP_UNIT_O <= PRE_UNIT_I;
					DONE_O      <= 1'b1;
				end else if (pre_inv) begin
					DEST_WE_O   <= 1'b1; // RULE4 RULE11
					DEST_DATA_O <= fpxu_encode(`FPXU_K_INDEF, 1'b1, PRE_FMT_I); // RULE11
					DONE_O      <= 1'b1;
				end else if (pre_zdv) begin
					DEST_WE_O   <= 1'b1; // RULE4 RULE15
					DEST_DATA_O <= fpxu_encode(`FPXU_K_INF, PRE_SIGN_A_I ^ PRE_SIGN_B_I, PRE_FMT_I); // RULE15
					DONE_O      <= 1'b1;
				end else begin
					GO_ON_O <= 1'b1; // RULE10 RULE13
				end
			end else if (post_take) begin
				// result path: trap and destination write are decided together
				DONE_O <= 1'b1;
				if (post_trap) begin
					TRAP_O      <= 1'b1; // RULE5
					TRAP_UNIT_O <= unit_q;
				end
				// simd traps keep the destination; stack keeps a biased value on unmasked overflow or underflow
				if (post_trap & unit_q) begin
					DEST_WE_O <= 1'b0; // RULE19
				end else if (ovf_unm | (post_trap & unf_unm)) begin
					DEST_WE_O   <= 1'b1; // RULE19
					DEST_DATA_O <= POST_BIASED_I; // RULE19
				end else if (post_ev[`FPXU_B_OVF]) begin
					// masked overflow swaps the rounded data for the rounding-mode default
					DEST_WE_O   <= 1'b1; // RULE4 RULE18
					DEST_DATA_O <= fpxu_encode(fpxu_ovf_kind(cur_rc, POST_SIGN_I), POST_SIGN_I, fmt_q); // RULE18 RULE20
				end else begin
					// no overflow: rounded data goes through, under a precision trap as well
					DEST_WE_O   <= 1'b1;
					DEST_DATA_O <= POST_DATA_I;
				end
			end
		end
	end

endmodule

// file: tb/fpxu_top_properties.sv
// Purpose: port-level properties of the exception flag/mask unit
// Assumes: one clock domain, active-low async reset
// Notes:   pulse outputs are judged in the single cycle they stand
`timescale 1ns/1ns
module fpxu_chk (
	input wire logic        CLK_I,
	input wire logic        RSTN_I,
	input wire logic        RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic        PRE_VALID_I,
	input wire logic        POST_VALID_I,
	input wire logic        BUSY_O,
	input wire logic        GO_ON_O,
	input wire logic        TRAP_O,
	input wire logic        TRAP_UNIT_O,
	input wire logic        DEST_WE_O,
	input wire logic        DONE_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// operand checks answer in the next cycle, before any result exists
	AST_PRE_ANSWER: assert property (
		PRE_VALID_I && !BUSY_O |=> GO_ON_O || DONE_O) else $error("operand check not answered");
	// result checks close the instruction one cycle after the result
	AST_POST_DONE: assert property (
		POST_VALID_I && BUSY_O |=> DONE_O && !BUSY_O) else $error("result check not answered");
	// nothing is reported without a request behind it
	AST_IDLE_QUIET: assert property (
		!BUSY_O && !PRE_VALID_I |=> !DONE_O && !TRAP_O) else $error("report without request");
	AST_TRAP_DONE: assert property (
		TRAP_O |-> DONE_O) else $error("trap without done");
	// after a masked response the same instruction keeps going
	AST_GO_WAIT: assert property (
		GO_ON_O |-> BUSY_O && !DONE_O) else $error("go on while not waiting");
	AST_BUSY_HOLD: assert property (
		BUSY_O && !POST_VALID_I |=> BUSY_O) else $error("busy dropped early");
	// an unmasked operand fault leaves the destination alone
	AST_PRE_TRAP: assert property (
		PRE_VALID_I && !BUSY_O ##1 TRAP_O |-> !DEST_WE_O) else $error("write on operand trap");
	AST_SIMD_TRAP: assert property (
		TRAP_O && TRAP_UNIT_O |-> !DEST_WE_O) else $error("simd trap wrote destination");
	AST_RD_QUIET: assert property (
		!RD_I |=> RDATA_O == 32'h0) else $error("read data outside read slot");
endmodule

bind fpxu_top fpxu_chk chk_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.PRE_VALID_I(PRE_VALID_I), .POST_VALID_I(POST_VALID_I), .BUSY_O(BUSY_O), .GO_ON_O(GO_ON_O),
	.TRAP_O(TRAP_O), .TRAP_UNIT_O(TRAP_UNIT_O), .DEST_WE_O(DEST_WE_O), .DONE_O(DONE_O));

// file: tb/fpxu_top_tb_top.sv
// Purpose: directed tests of flags, masks and default results
// Assumes: single-format results land in the low 32 bits of the destination
// Notes:   result data are held constant; tiny and inexact are raised for the last tests
`timescale 1ns/1ns
module fpxu_top_tb_top;
	logic        CLK_I = 1'b0, RSTN_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
	logic [7:0]  ADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0, RDATA_O;
	logic        PRE_VALID_I = 1'b0, PRE_UNIT_I = 1'b0, PRE_INVALID_I = 1'b0, PRE_DENORM_I = 1'b0;
	logic        PRE_ZDIV_I = 1'b0, PRE_SIGN_A_I = 1'b0, PRE_SIGN_B_I = 1'b0, POST_VALID_I = 1'b0;
	logic        POST_SIGN_I = 1'b0, BUSY_O, GO_ON_O, TRAP_O, TRAP_UNIT_O, DEST_WE_O, DONE_O;
	logic        POST_TINY_I = 1'b0, POST_INEXACT_I = 1'b0;
	logic [1:0]  PRE_FMT_I = 2'h0;
	logic [17:0] POST_EXP_I = 18'h0;
	logic [79:0] DEST_DATA_O;
	int          fail_count = 0, n_compared = 0, cyc = 0, k;
	fpxu_top dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
		.RD_I(RD_I), .RDATA_O(RDATA_O), .PRE_VALID_I(PRE_VALID_I), .PRE_UNIT_I(PRE_UNIT_I),
		.PRE_FMT_I(PRE_FMT_I), .PRE_INVALID_I(PRE_INVALID_I), .PRE_DENORM_I(PRE_DENORM_I),
		.PRE_ZDIV_I(PRE_ZDIV_I), .PRE_SIGN_A_I(PRE_SIGN_A_I), .PRE_SIGN_B_I(PRE_SIGN_B_I),
		.POST_VALID_I(POST_VALID_I), .POST_EXP_I(POST_EXP_I), .POST_SIGN_I(POST_SIGN_I),
		.POST_TINY_I(POST_TINY_I), .POST_INEXACT_I(POST_INEXACT_I), .POST_DATA_I(80'h1234_5678),
		.POST_BIASED_I(80'h9abc_def0), .BUSY_O(BUSY_O), .GO_ON_O(GO_ON_O), .TRAP_O(TRAP_O),
		.TRAP_UNIT_O(TRAP_UNIT_O), .DEST_WE_O(DEST_WE_O), .DEST_DATA_O(DEST_DATA_O), .DONE_O(DONE_O));
	initial begin
		forever #2 CLK_I = ~CLK_I;
	end
	// a hang is cut short well after the directed run would have ended
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			final_report();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] want);
		n_compared = n_compared + 1;
		if (seen !== want) begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		{WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge CLK_I);
		{RD_I, ADDR_I} <= {1'b1, a};
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 chk(RDATA_O, want);
	endtask
	// e = {go on, trap, write}; sign b is taken from exponent bit 0
	// ed is the low word for single, bits 79:48 for double and extended
	task op(input logic u, input logic [1:0] fm, input logic [2:0] ev, input logic [17:0] ex,
		input logic sg, input logic [2:0] e, input logic [31:0] ed);
		@(posedge CLK_I);
		{PRE_VALID_I, PRE_UNIT_I, PRE_FMT_I, PRE_ZDIV_I, PRE_DENORM_I, PRE_INVALID_I} <= {1'b1, u, fm, ev};
		{PRE_SIGN_A_I, PRE_SIGN_B_I} <= {sg, ex[0]};
		@(posedge CLK_I);
		PRE_VALID_I <= 1'b0;
		#1 chk(GO_ON_O, e[2]);
		if (e[2]) begin
			@(posedge CLK_I);
			{POST_VALID_I, POST_EXP_I, POST_SIGN_I} <= {1'b1, ex, sg};
			@(posedge CLK_I);
			POST_VALID_I <= 1'b0;
			#1;
		end
		chk({DONE_O, TRAP_O, DEST_WE_O}, {1'b1, e[1:0]});
		if (e[0] && fm == 2'h0) chk(DEST_DATA_O[31:0], ed);
		if (e[0] && fm != 2'h0) chk(DEST_DATA_O[79:48], ed);
		if (e[1]) chk(TRAP_UNIT_O, u);
	endtask
	task final_report();
		$display("mismatches %0d compares %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		rd(8'h00, 32'h3f);
		rd(8'h08, 32'h1f80);
		rd(8'h04, 32'h0);
		rd(8'h0c, 32'h0);
		op(0, 0, 3'b010, 0, 0, 3'b101, 32'h1234_5678);
		rd(8'h04, 32'h2);
		op(0, 0, 3'b001, 0, 0, 3'b001, 32'hffc0_0000);
		op(1, 0, 3'b100, 1, 1, 3'b001, 32'h7f80_0000);
		rd(8'h04, 32'h3);
		rd(8'h08, 32'h1f84);
		for (k = 0; k < 3; k++) begin
			wr(8'h00, 32'h3f & ~(32'h1 << k));
			op(0, 0, 3'(1 << k), 0, 0, 3'b010, 0);
		end
		// every rounding mode against both signs, table of masked overflow results
		for (k = 0; k < 8; k++) begin
			wr(8'h00, 32'h3f | ((k >> 1) << 10));
			op(0, 0, 0, 18'd128, k[0], 3'b101, (k < 2 || k == 3 || k == 4) ? {k[0], 8'hff, 23'h0} :
				{k[0], 8'hfe, 23'h7fffff});
		end
		rd(8'h00, 32'hc3f);
		wr(8'h04, 32'h0);
		op(0, 0, 0, 18'd127, 0, 3'b101, 32'h1234_5678);
		op(0, 1, 0, 18'd1023, 0, 3'b101, 0);
		op(0, 2, 0, 18'd16383, 0, 3'b101, 0);
		rd(8'h04, 32'h0);
		op(0, 1, 0, 18'd1024, 0, 3'b101, 32'h7fef);
		op(0, 2, 0, 18'd16384, 1, 3'b101, 32'hfffe_ffff);
		rd(8'h04, 32'h8);
		wr(8'h00, 32'h37);
		op(0, 0, 0, 18'd128, 0, 3'b111, 32'h9abc_def0);
		wr(8'h08, 32'h1b80);
		op(1, 0, 0, 18'd128, 0, 3'b110, 0);
		rd(8'h08, 32'h1b88);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h0);
		// tiny and inexact results: flagged on either unit, trapped only where unmasked
		@(posedge CLK_I);
		{POST_TINY_I, POST_INEXACT_I} <= 2'b11;
		wr(8'h00, 32'h3f);
		op(0, 0, 0, 0, 0, 3'b101, 32'h1234_5678);
		rd(8'h04, 32'h30);
		op(1, 0, 0, 0, 0, 3'b101, 32'h1234_5678);
		rd(8'h08, 32'h1bb8);
		wr(8'h00, 32'h2f);
		op(0, 0, 0, 0, 0, 3'b111, 32'h9abc_def0);
		final_report();
	end
endmodule
